// file: clc_pkg.sv
// Overview of operation
// - Inhibit clear: valid input above UV forces ON, no wait
// - Inhibit set: input present enables wait mode
// - Restart bit clears timers, restarts charging
// - Timer enable selects taper status source
// - Current field scales constant-current level
// - USB limit 100/500 mA, needs USB allowed
// - USB allowed clear forbids USB charging
// - Charge enable; wall input preferred
// - On-time counts 10 ms per step
// - Status period counts 100 ms per step
// - Aux period counts 100 ms per step
// - Status mode: charger, blink, off, on
// - Aux mode: off, blink, off, on
// - Forced fixed-frequency bit for both converters
// - Undervoltage select chooses lockout threshold
// - Sleep pin plus enable picks wait/low-power
// - Main setup resets 32h/33h, bit0 from strap
// - Low-power pin enable gates sleep pin
package clc_pkg;
  localparam logic [7:0] ADDR_CHARGER_SETUP   = 8'h07;
  localparam logic [7:0] ADDR_STATUS_LED_ON   = 8'h08;
  localparam logic [7:0] ADDR_STATUS_LED_PER  = 8'h09;
  localparam logic [7:0] ADDR_AUX_LED_ON      = 8'h0a;
  localparam logic [7:0] ADDR_AUX_LED_PER     = 8'h0b;
  localparam logic [7:0] ADDR_MAIN_CONV       = 8'h0c;
  localparam logic [7:0] RST_CHARGER_SETUP    = 8'h1b;
  localparam logic [7:0] RST_LED              = 8'h00;
  localparam logic [7:0] RST_MAIN_CONV        = 8'h32;
  localparam int BIT_INHIBIT    = 7;
  localparam int BIT_RESTART    = 6;
  localparam int BIT_TIMER_EN   = 5;
  localparam int BIT_CUR_MSB    = 4;
  localparam int BIT_CUR_LSB    = 3;
  localparam int BIT_USB_500    = 2;
  localparam int BIT_USB_ALLOW  = 1;
  localparam int BIT_CHG_EN     = 0;
  localparam int BIT_FORCED     = 7;
  localparam int BIT_UV_HI      = 6;
  localparam int BIT_UV_LO      = 5;
  localparam int BIT_SUPPLY_SEL = 4;
  localparam int BIT_LP_EN      = 3;
  localparam int BIT_MAIN_DIS   = 2;
  localparam int BIT_STRAP      = 0;
  localparam int BIT_MODE       = 7;
  localparam int CLK_HZ         = 20000000;
  localparam int TICK_MS        = 10;
  localparam int TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int PER_STEP_TICKS = 10;
endpackage

// file: clc_tick.sv
`timescale 1ns/10ps
module clc_tick (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  output logic      tick_o
);
  localparam logic [17:0] LAST = 18'(clc_pkg::TICK_CYCLES - 1);
  logic [17:0] cnt_r;
  wire         wrap = (cnt_r == LAST);
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r  <= 18'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_r  <= wrap ? 18'h0 : cnt_r + 18'h1;
      tick_o <= wrap;
    end
  end
endmodule // clc_tick

// file: clc_blink.sv
`timescale 1ns/10ps
module clc_blink (
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic       tick_i,
  input  wire logic [6:0] on_i,
  input  wire logic [6:0] per_i,
  output logic            on_o
);
  logic [10:0] pos_r;
  wire  [10:0] on_ticks  = 11'(on_i == 7'h0 ? 7'h1 : on_i);
  wire  [10:0] per_ticks = 11'((per_i == 7'h0 ? 7'h1 : per_i)
                               * clc_pkg::PER_STEP_TICKS);
  wire         at_end    = (pos_r >= per_ticks - 11'h1);
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pos_r <= 11'h0;
    end else if (tick_i) begin
      pos_r <= at_end ? 11'h0 : pos_r + 11'h1;
    end
  end
  assign on_o = (pos_r < on_ticks);
endmodule // clc_blink

// file: charger_led_converter_config.sv
`timescale 1ns/10ps
module charger_led_converter_config (
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic [7:0]      rdata_o,
  input  wire logic       main_voltage_strap_i,
  input  wire logic       sleep_request_pin_i,
  input  wire logic       usb_valid_i,
  input  wire logic       wall_valid_i,
  input  wire logic       above_uv_i,
  input  wire logic       taper_cmp_i,
  input  wire logic       taper_timer_i,
  input  wire logic       charger_led_req_i,
  output logic            force_on_o,
  output logic            wait_enable_o,
  output logic            charger_restart_o,
  output logic            timers_enable_o,
  output logic            charge_status_bit3_o,
  output logic [1:0]      current_scale_o,
  output logic            usb_500ma_o,
  output logic            charge_from_usb_o,
  output logic            charge_from_wall_o,
  output logic            forced_fixed_freq_o,
  output logic [1:0]      undervolt_threshold_sel_o,
  output logic            main_discharge_o,
  output logic [1:0]      main_rail_sel_o,
  output logic            wait_mode_req_o,
  output logic            low_power_req_o,
  output logic            status_led_pin_o,
  output logic            status_led_pin_oe_o,
  output logic            aux_led_pin_o,
  output logic            aux_led_pin_oe_o
);
  logic [7:0] chg_r, s_on_r, s_per_r, a_on_r, a_per_r, main_r;
  logic       strap_done_r;
  logic       restart_d_r;
  logic       tick;
  logic       s_blink, a_blink;

  wire w_chg   = wr_en_i && (addr_i == clc_pkg::ADDR_CHARGER_SETUP);
  wire w_s_on  = wr_en_i && (addr_i == clc_pkg::ADDR_STATUS_LED_ON);
  wire w_s_per = wr_en_i && (addr_i == clc_pkg::ADDR_STATUS_LED_PER);
  wire w_a_on  = wr_en_i && (addr_i == clc_pkg::ADDR_AUX_LED_ON);
  wire w_a_per = wr_en_i && (addr_i == clc_pkg::ADDR_AUX_LED_PER);
  wire w_main  = wr_en_i && (addr_i == clc_pkg::ADDR_MAIN_CONV);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chg_r   <= clc_pkg::RST_CHARGER_SETUP;
      s_on_r  <= clc_pkg::RST_LED;
      s_per_r <= clc_pkg::RST_LED;
      a_on_r  <= clc_pkg::RST_LED;
      a_per_r <= clc_pkg::RST_LED;
    end else begin
      if (w_chg)   chg_r   <= wdata_i;
      if (w_s_on)  s_on_r  <= wdata_i;
      if (w_s_per) s_per_r <= wdata_i;
      if (w_a_on)  a_on_r  <= wdata_i;
      if (w_a_per) a_per_r <= wdata_i;
    end
  end

  // Strap caught on the first edge after release
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      main_r       <= clc_pkg::RST_MAIN_CONV;
      strap_done_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
      if (w_main) begin
        main_r <= wdata_i;
      end else if (!strap_done_r) begin
        main_r[clc_pkg::BIT_STRAP] <= main_voltage_strap_i;
      end
    end
  end

  // Restart pulse on rising edge of restart bit
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      restart_d_r <= 1'b0;
    end else begin
      restart_d_r <= chg_r[clc_pkg::BIT_RESTART];
    end
  end
  assign charger_restart_o = chg_r[clc_pkg::BIT_RESTART] && !restart_d_r;

  wire inhibit    = chg_r[clc_pkg::BIT_INHIBIT];
  wire src_valid  = usb_valid_i || wall_valid_i;
  assign force_on_o    = !inhibit && src_valid && above_uv_i;
  assign wait_enable_o = inhibit && src_valid;

  assign timers_enable_o      = chg_r[clc_pkg::BIT_TIMER_EN];
  assign charge_status_bit3_o = timers_enable_o ? taper_timer_i : taper_cmp_i;
  assign current_scale_o      = chg_r[clc_pkg::BIT_CUR_MSB:clc_pkg::BIT_CUR_LSB];

  wire chg_en    = chg_r[clc_pkg::BIT_CHG_EN];
  wire usb_allow = chg_r[clc_pkg::BIT_USB_ALLOW];
  assign usb_500ma_o        = usb_allow && chg_r[clc_pkg::BIT_USB_500];
  assign charge_from_wall_o = chg_en && wall_valid_i;
  assign charge_from_usb_o  = chg_en && usb_allow && usb_valid_i
                              && !wall_valid_i;

  assign forced_fixed_freq_o       = main_r[clc_pkg::BIT_FORCED];
  assign undervolt_threshold_sel_o = main_r[clc_pkg::BIT_UV_HI:clc_pkg::BIT_UV_LO];
  assign main_discharge_o          = main_r[clc_pkg::BIT_MAIN_DIS];
  assign main_rail_sel_o           = main_r[1:0];

  wire sleep_act = sleep_request_pin_i && main_r[clc_pkg::BIT_LP_EN];
  assign wait_mode_req_o = sleep_act && !main_r[clc_pkg::BIT_SUPPLY_SEL];
  assign low_power_req_o = sleep_act && main_r[clc_pkg::BIT_SUPPLY_SEL];

  clc_tick u_tick (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .tick_o  (tick)
  );

  clc_blink u_s_blink (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .tick_i  (tick),
    .on_i    (s_on_r[6:0]),
    .per_i   (s_per_r[6:0]),
    .on_o    (s_blink)
  );

  clc_blink u_a_blink (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .tick_i  (tick),
    .on_i    (a_on_r[6:0]),
    .per_i   (a_per_r[6:0]),
    .on_o    (a_blink)
  );

  wire [1:0] s_mode = {s_on_r[clc_pkg::BIT_MODE], s_per_r[clc_pkg::BIT_MODE]};
  wire [1:0] a_mode = {a_on_r[clc_pkg::BIT_MODE], a_per_r[clc_pkg::BIT_MODE]};
  wire s_drive = (s_mode == 2'h0) ? charger_led_req_i :
                 (s_mode == 2'h1) ? s_blink : (s_mode == 2'h3);
  wire a_drive = (a_mode == 2'h1) ? a_blink : (a_mode == 2'h3);

  // Open drain: pull low while enabled
  assign status_led_pin_o    = 1'b0;
  assign status_led_pin_oe_o = s_drive;
  assign aux_led_pin_o       = 1'b0;
  assign aux_led_pin_oe_o    = a_drive;

  always_comb begin
    unique case (addr_i)
      clc_pkg::ADDR_CHARGER_SETUP:  rdata_o = chg_r;
      clc_pkg::ADDR_STATUS_LED_ON:  rdata_o = s_on_r;
      clc_pkg::ADDR_STATUS_LED_PER: rdata_o = s_per_r;
      clc_pkg::ADDR_AUX_LED_ON:     rdata_o = a_on_r;
      clc_pkg::ADDR_AUX_LED_PER:    rdata_o = a_per_r;
      clc_pkg::ADDR_MAIN_CONV:      rdata_o = main_r;
      default:                      rdata_o = 8'h00;
    endcase
  end
endmodule // charger_led_converter_config

// file: clc_host.sv
`timescale 1ns/10ps
module clc_host (
  input  wire logic clock_i,
  output logic       wr_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    wr_en_o = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
  end
  // One-cycle write strobe, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    wr_en_o = 1'b1;
    addr_o  = a;
    wdata_o = d;
    @(negedge clock_i);
    wr_en_o = 1'b0;
    wdata_o = ~d;
  endtask
  // Read is combinational on the address
  task automatic rd(input logic [7:0] a);
    @(negedge clock_i);
    addr_o = a;
    #1;
  endtask
endmodule // clc_host

// file: clc_checker.sv
`timescale 1ns/10ps
module clc_checker (
  input wire logic       clock_i,
  input wire logic       nrst_i,
  input wire logic       wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       usb_valid_i,
  input wire logic       wall_valid_i,
  input wire logic       above_uv_i,
  input wire logic       taper_cmp_i,
  input wire logic       taper_timer_i,
  input wire logic       sleep_request_pin_i,
  input wire logic       force_on_o,
  input wire logic       wait_enable_o,
  input wire logic       charger_restart_o,
  input wire logic       timers_enable_o,
  input wire logic       charge_status_bit3_o,
  input wire logic       charge_from_usb_o,
  input wire logic       charge_from_wall_o,
  input wire logic       wait_mode_req_o,
  input wire logic       low_power_req_o
);
  wire restart_wr = wr_en_i && (addr_i == clc_pkg::ADDR_CHARGER_SETUP)
                    && wdata_i[clc_pkg::BIT_RESTART];
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence one_pulse;
    charger_restart_o ##1 !charger_restart_o;
  endsequence
  restart_pulse_a: assert property ($rose(charger_restart_o) |-> one_pulse)
    else $error("restart pulse not one cycle");
  restart_cause_a: assert property ($rose(charger_restart_o) |->
    $past(restart_wr)) else $error("restart without write");
  status_src_a: assert property (charge_status_bit3_o ==
    (timers_enable_o ? taper_timer_i : taper_cmp_i)) else $error("status bit3 source");
  usb_route_a: assert property (charge_from_usb_o |-> usb_valid_i && !wall_valid_i)
    else $error("usb charging wrongly");
  wall_route_a: assert property (charge_from_wall_o |-> wall_valid_i)
    else $error("wall charging without source");
  force_on_a: assert property (force_on_o |-> (usb_valid_i || wall_valid_i) &&
    above_uv_i && !wait_enable_o) else $error("force on without cause");
  wait_req_a: assert property (wait_mode_req_o |-> sleep_request_pin_i && !low_power_req_o)
    else $error("wait request wrong");
  low_power_a: assert property (low_power_req_o |-> sleep_request_pin_i)
    else $error("low power without sleep pin");
endmodule // clc_checker

bind charger_led_converter_config clc_checker i_clc_checker (.clock_i, .nrst_i, .wr_en_i,
  .addr_i, .wdata_i, .usb_valid_i, .wall_valid_i, .above_uv_i, .taper_cmp_i, .taper_timer_i,
  .sleep_request_pin_i, .force_on_o, .wait_enable_o, .charger_restart_o, .timers_enable_o,
  .charge_status_bit3_o, .charge_from_usb_o, .charge_from_wall_o, .wait_mode_req_o,
  .low_power_req_o);

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        clock_i, nrst_i, main_voltage_strap_i, sleep_request_pin_i, usb_valid_i;
  logic        wall_valid_i, above_uv_i, taper_cmp_i, taper_timer_i, charger_led_req_i;
  logic        wr_en_i, force_on_o, wait_enable_o, charger_restart_o, timers_enable_o;
  logic        charge_status_bit3_o, usb_500ma_o, charge_from_usb_o, charge_from_wall_o;
  logic        forced_fixed_freq_o, main_discharge_o, wait_mode_req_o, low_power_req_o;
  logic        status_led_pin_o, status_led_pin_oe_o, aux_led_pin_o, aux_led_pin_oe_o;
  logic [7:0]  addr_i, wdata_i, rdata_o;
  logic [1:0]  current_scale_o, undervolt_threshold_sel_o, main_rail_sel_o;
  logic [15:0] rows [4] = '{16'h1b19, 16'h3412, 16'h0b09, 16'h0705};
  int          n_mismatch, num_checks;
  clc_host i_clc_host (.clock_i, .wr_en_o(wr_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
  charger_led_converter_config i_charger_led_converter_config (.clock_i, .nrst_i, .wr_en_i,
    .addr_i, .wdata_i, .rdata_o, .main_voltage_strap_i, .sleep_request_pin_i, .usb_valid_i,
    .wall_valid_i, .above_uv_i, .taper_cmp_i, .taper_timer_i, .charger_led_req_i, .force_on_o,
    .wait_enable_o, .charger_restart_o, .timers_enable_o, .charge_status_bit3_o,
    .current_scale_o, .usb_500ma_o, .charge_from_usb_o, .charge_from_wall_o,
    .forced_fixed_freq_o, .undervolt_threshold_sel_o, .main_discharge_o, .main_rail_sel_o,
    .wait_mode_req_o, .low_power_req_o, .status_led_pin_o, .status_led_pin_oe_o,
    .aux_led_pin_o, .aux_led_pin_oe_o);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    #2000000;
    n_mismatch++;
    test_done();
  end
  initial begin
    {nrst_i, sleep_request_pin_i, taper_timer_i, wall_valid_i} = 4'h0;
    {main_voltage_strap_i, usb_valid_i, above_uv_i, taper_cmp_i, charger_led_req_i} = 5'h1f;
    repeat (8) @(negedge clock_i);
    nrst_i = 1'b1;
    for (int a = 7; a < 14; a++) begin
      i_clc_host.rd(8'(a));
      chk(rdata_o, a == 7 ? 8'h1b : (a == 12 ? 8'h33 : 8'h00));
    end
    chk({5'h0, main_discharge_o, main_rail_sel_o}, 8'h03);
    foreach (rows[k]) begin
      i_clc_host.wr(8'h07, rows[k][15:8]);
      i_clc_host.rd(8'h07);
      chk(rdata_o, rows[k][15:8]);
      chk({3'h0, current_scale_o, usb_500ma_o, timers_enable_o, charge_status_bit3_o},
          rows[k][7:0]);
    end
    for (int i = 0; i < 4; i++) begin
      i_clc_host.wr(8'h0c, 8'(i * 32 + (i % 2) * 128));
      chk({5'h0, forced_fixed_freq_o, undervolt_threshold_sel_o}, 8'(i + (i % 2) * 4));
    end
    wall_valid_i = 1'b1;
    #1;
    chk({4'h0, force_on_o, wait_enable_o, charge_from_wall_o, charge_from_usb_o}, 8'h0a);
    above_uv_i = 1'b0;
    #1;
    chk({7'h0, force_on_o}, 8'h00);
    above_uv_i = 1'b1;
    @(negedge clock_i);
    wall_valid_i = 1'b0;
    #1;
    chk({6'h0, charge_from_wall_o, charge_from_usb_o}, 8'h01);
    i_clc_host.wr(8'h07, 8'h85);
    chk({4'h0, force_on_o, wait_enable_o, charge_from_wall_o, charge_from_usb_o}, 8'h04);
    wall_valid_i = 1'b1;
    i_clc_host.wr(8'h07, 8'h1a);
    chk({6'h0, charge_from_wall_o, charge_from_usb_o}, 8'h00);
    i_clc_host.wr(8'h07, 8'h5b);
    chk({7'h0, charger_restart_o}, 8'h01);
    @(negedge clock_i);
    chk({7'h0, charger_restart_o}, 8'h00);
    i_clc_host.wr(8'h07, 8'h1b);
    sleep_request_pin_i = 1'b1;
    i_clc_host.wr(8'h0c, 8'h08);
    chk({6'h0, wait_mode_req_o, low_power_req_o}, 8'h02);
    i_clc_host.wr(8'h0c, 8'h18);
    chk({6'h0, wait_mode_req_o, low_power_req_o}, 8'h01);
    i_clc_host.wr(8'h0c, 8'h10);
    chk({6'h0, wait_mode_req_o, low_power_req_o}, 8'h00);
    for (int a = 8; a < 12; a++) i_clc_host.wr(8'(a), 8'h80);
    chk({4'h0, status_led_pin_o, status_led_pin_oe_o, aux_led_pin_o, aux_led_pin_oe_o},
        8'h05);
    i_clc_host.wr(8'h09, 8'h00);
    i_clc_host.wr(8'h0b, 8'h00);
    chk({6'h0, status_led_pin_oe_o, aux_led_pin_oe_o}, 8'h00);
    i_clc_host.wr(8'h08, 8'h00);
    i_clc_host.wr(8'h0a, 8'h00);
    chk({6'h0, status_led_pin_oe_o, aux_led_pin_oe_o}, 8'h02);
    charger_led_req_i = 1'b0;
    #1;
    chk({7'h0, status_led_pin_oe_o}, 8'h00);
    i_clc_host.wr(8'h09, 8'h80);
    i_clc_host.wr(8'h0b, 8'h80);
    chk({6'h0, status_led_pin_oe_o, aux_led_pin_oe_o}, 8'h03);
    main_voltage_strap_i = 1'b0;
    nrst_i = 1'b0;
    repeat (2) @(negedge clock_i);
    nrst_i = 1'b1;
    i_clc_host.rd(8'h0c);
    chk(rdata_o, 8'h32);
    chk({5'h0, main_discharge_o, main_rail_sel_o}, 8'h02);
    i_clc_host.rd(8'h07);
    chk(rdata_o, 8'h1b);
    chk({6'h0, status_led_pin_oe_o, aux_led_pin_oe_o}, 8'h00);
    test_done();
  end
endmodule // testbench
